// File: kws_key_model.sv
`timescale 1ns/100ps
// Key switches and halt button outside the wake pins
module kws_key_model (
   input  wire logic       sys_clk,
   output logic [3:0]      wake_key,
   output logic            halt_pin
);
   // Released keys pull up, so idle high; halt idles low
   initial begin
      wake_key = 4'hf;
      halt_pin = 1'b0;
   end
   // Change one key just after an edge
   task automatic set_key(input int k, input logic v);
      @(posedge sys_clk);
      wake_key[k] <= v;
   endtask
   // Press or release the halt button
   task automatic set_halt(input logic v);
      @(posedge sys_clk);
      halt_pin <= v;
   endtask
endmodule // kws_key_model

// File: kws_pkg.sv
package kws_pkg;
   // Bus geometry and key count
   localparam int             KWS_ADDR_W      = 16;
   localparam int             KWS_DATA_W      = 32;
   localparam int             KWS_KEYS        = 4;
   // Register indices; byte address is four times the index
   localparam logic [15:0]    KWS_IDX_WAKE_EN = 16'h0faa;
   localparam logic [15:0]    KWS_IDX_CTRL    = 16'h0fab;
   localparam logic [15:0]    KWS_IDX_STATUS  = 16'h0fac;
   // Field positions of wake_input_enable
   localparam int             KWS_EN_LSB      = 4;
   localparam int             KWS_EN_MSB      = 7;
   // Field positions of the control register
   localparam int             KWS_CTRL_RELM   = 0;
   localparam int             KWS_CTRL_STOP   = 1;
   // Field positions of the status register
   localparam int             KWS_ST_STANDBY  = 0;
   localparam int             KWS_ST_HALT     = 1;
   localparam int             KWS_ST_KEY_LSB  = 4;
   // Reset values
   localparam logic [3:0]     KWS_EN_RST      = 4'h0;
   localparam logic           KWS_RELM_RST    = 1'b0;
   // Standby sequencer states
   typedef enum logic [1:0] {
      KWS_RUN     = 2'b00,
      KWS_STANDBY = 2'b01,
      KWS_WARMUP  = 2'b10
   } kws_state_t;
endpackage

// File: kws_stop_release.sv
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1 - Four write-only wake enables in bits 7..4
// RQ2 - Reset clears enables; low bits unused
// RQ3 - Wake keys end standby besides halt pin; here only in level mode, edge mode ignores keys
// RQ4 - Enabled key low ends standby; here only in level mode (relm_reg 1), edge mode ignores keys
// RQ5 - Release condition at entry skips standby, warms up
// RQ6 - Level: halt high, key low; edge: halt rise
// RQ7 - Edge mode: software disables or holds keys high
// RQ8 - Halt pin always takes part, no enable
// RQ9 - Key wake: halt pin held low externally
// RQ10 - Software sets wake port pins as inputs
// RQ11 - Key levels readable as port data
// RQ12 - Software checks keys high before standby
// RQ13 - No analog input on enabled wake pin
// RQ14 - Wake request formed without clock
module kws_stop_release
   import kws_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    resetn,
   input  wire logic                    clk_en,
   // Avalon-MM slave
   input  wire logic [KWS_ADDR_W-1:0]   avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [KWS_DATA_W-1:0]   avs_writedata,
   output logic      [KWS_DATA_W-1:0]   avs_readdata,
   output logic                         avs_waitrequest,
   // Pins
   input  wire logic [KWS_KEYS-1:0]     wake_key,
   input  wire logic                    port2_bit0,
   // Towards the system controller
   output logic                         clock_stop,
   output logic                         warmup_start
);

   //////////////////////////////////////////////////////////////////////////
   // Declarations
   kws_wake_if                   wif ();          // Link to detector
   logic [KWS_KEYS-1:0]          wake_en_reg;     // Wake enables
   logic                         relm_reg;        // 1 level, 0 edge mode
   logic                         wait_reg;        // Bus wait state
   logic [KWS_DATA_W-1:0]        rdata_reg;       // Read data
   logic                         stop_req;        // Standby request strobe
   logic [1:0]                   req_sync_reg;    // Level request sync
   logic [1:0]                   halt_sync_reg;   // Halt pin sync
   logic [KWS_KEYS-1:0]          key_s1_reg;      // Key pin sync stage 1
   logic [KWS_KEYS-1:0]          key_s2_reg;      // Key pin sync stage 2
   logic                         halt_prev_reg;   // Halt history for edges
   logic                         halt_rise;       // Rising edge of halt
   logic                         key_low_s;       // Synced enabled key low
   logic                         release_now;     // Release in current mode
   logic                         entry_block;     // Entry refused condition
   kws_state_t                   state_reg;       // Sequencer state
   kws_state_t                   state_next;      // Next sequencer state
   logic                         acc;             // Access completes now
   logic                         clock_stop_reg;  // Clock-stop output
   logic                         warmup_reg;      // Warm-up pulse output

   //////////////////////////////////////////////////////////////////////////
   // Helpers

   // Register index from a byte address; unaligned addresses never hit
   function automatic logic [15:0] kws_index(
      input logic [KWS_ADDR_W-1:0] a);
      kws_index = {2'b00, a[KWS_ADDR_W-1:2]};
   endfunction

   function automatic logic kws_hit(input logic [KWS_ADDR_W-1:0] a,
                                    input logic [15:0] idx);
      kws_hit = (a[1:0] == 2'b00) && (kws_index(a) == idx);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Clockless detector

   assign wif.wake_key = wake_key;
   assign wif.halt_pin = port2_bit0;
   assign wif.wake_en  = wake_en_reg;

   kws_wake_detect u_detect (
      .w (wif.det)
   );

   //////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, then the access completes

   assign acc = (avs_read | avs_write) & ~wait_reg;

   // Wait state: drops one cycle after a request, rises after completion
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wait_reg <= 1'b1;
      end else if (clk_en) begin
         if (acc) begin
            wait_reg <= 1'b1;
         end else if (avs_read | avs_write) begin
            wait_reg <= 1'b0;
         end
      end
   end

   // Read data, prepared while waitrequest is still high
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= '0;
      end else if (clk_en) begin
         rdata_reg <= '0;
         if (avs_read && wait_reg) begin
            if (kws_hit(avs_address, KWS_IDX_CTRL)) begin
               rdata_reg[KWS_CTRL_RELM] <= relm_reg;
            end else if (kws_hit(avs_address, KWS_IDX_STATUS)) begin
               // Key levels through the port path, not the detector
               rdata_reg[KWS_ST_STANDBY] <= clock_stop_reg;
               rdata_reg[KWS_ST_HALT]    <= halt_sync_reg[1];
               rdata_reg[KWS_ST_KEY_LSB +: KWS_KEYS] <= key_s2_reg; // RQ11
            end
            // Enable register is write only and reads as zero
         end
      end
   end

   // Wake enables; the low four bits of the word are dropped
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wake_en_reg <= KWS_EN_RST; // RQ2
      end else if (clk_en) begin
         if (acc && avs_write && kws_hit(avs_address, KWS_IDX_WAKE_EN)) begin
            wake_en_reg <= avs_writedata[KWS_EN_MSB:KWS_EN_LSB]; // RQ1
         end
      end
   end

   // Release mode bit of the control register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         relm_reg <= KWS_RELM_RST;
      end else if (clk_en) begin
         if (acc && avs_write && kws_hit(avs_address, KWS_IDX_CTRL)) begin
            relm_reg <= avs_writedata[KWS_CTRL_RELM];
         end
      end
   end

   // Writing one to the stop bit is the standby instruction
   assign stop_req = acc && avs_write && kws_hit(avs_address, KWS_IDX_CTRL)
                     && avs_writedata[KWS_CTRL_STOP];

   //////////////////////////////////////////////////////////////////////////
   // Synchronisers: pins and the clockless request are asynchronous

   // Combined level request, formed without a clock
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         req_sync_reg <= 2'b00;
      end else if (clk_en) begin
         req_sync_reg <= {req_sync_reg[0], wif.level_req}; // RQ14
      end
   end

   // Halt pin, for edge mode and status
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         halt_sync_reg <= 2'b00;
         halt_prev_reg <= 1'b0;
      end else if (clk_en) begin
         halt_sync_reg <= {halt_sync_reg[0], port2_bit0};
         halt_prev_reg <= halt_sync_reg[1];
      end
   end

   // Key pins; keys idle high, so reset to ones
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         key_s1_reg <= '1;
         key_s2_reg <= '1;
      end else if (clk_en) begin
         key_s1_reg <= wake_key;
         key_s2_reg <= key_s1_reg;
      end
   end

   assign halt_rise = halt_sync_reg[1] & ~halt_prev_reg;
   assign key_low_s = |(wake_en_reg & ~key_s2_reg); // RQ4

   // Level mode: halt high or enabled key low; edge mode: halt rise only
   // Keys are ignored for release in edge mode, so stray lows cannot end standby
   assign release_now = relm_reg ? req_sync_reg[1] : halt_rise; // RQ6 RQ8

   // Entry refused when halt is high or an enabled key is already low
   assign entry_block = halt_sync_reg[1] | key_low_s; // RQ5

   //////////////////////////////////////////////////////////////////////////
   // Standby sequencer

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         KWS_RUN: begin
            if (stop_req) begin
               // Immediate warm-up instead of entering standby
               state_next = entry_block ? KWS_WARMUP : KWS_STANDBY; // RQ5
            end
         end
         KWS_STANDBY: begin
            if (release_now) begin
               state_next = KWS_WARMUP; // RQ3 RQ4 RQ6
            end
         end
         KWS_WARMUP: begin
            // Warm-up timing belongs to the system controller
            state_next = KWS_RUN;
         end
         default: begin
            state_next = KWS_RUN;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= KWS_RUN;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // Outputs from flops: clock stop level and warm-up pulse
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         clock_stop_reg <= 1'b0;
         warmup_reg     <= 1'b0;
      end else if (clk_en) begin
         clock_stop_reg <= (state_next == KWS_STANDBY);
         warmup_reg     <= (state_next == KWS_WARMUP);
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign clock_stop      = clock_stop_reg;
   assign warmup_start    = warmup_reg;

endmodule // kws_stop_release

// File: kws_stop_release_sva.sv
`timescale 1ns/100ps
// Port-level checker of the wake sequencer
module kws_stop_release_sva
   import kws_pkg::*;
(
   input wire logic                  sys_clk,
   input wire logic                  resetn,
   input wire logic                  clk_en,
   input wire logic [KWS_ADDR_W-1:0] avs_address,
   input wire logic                  avs_read,
   input wire logic                  avs_write,
   input wire logic [KWS_DATA_W-1:0] avs_readdata,
   input wire logic                  avs_waitrequest,
   input wire logic [KWS_KEYS-1:0]   wake_key,
   input wire logic                  port2_bit0,
   input wire logic                  clock_stop,
   input wire logic                  warmup_start
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // A fresh request while the slave still stalls
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest && clk_en;
   endsequence
   // Standby with every pin at its idle level
   sequence s_quiet;
      clock_stop && !port2_bit0 && (&wake_key);
   endsequence
   chk_wait_once: assert property (s_req |=> !avs_waitrequest)
      else $error("waitrequest did not drop");
   chk_wait_short: assert property (!avs_waitrequest && clk_en
      |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_read_idle: assert property (avs_waitrequest |-> avs_readdata == '0)
      else $error("read data outside a completion");
   chk_enable_wo: assert property (avs_read && !avs_waitrequest &&
      avs_address == (KWS_IDX_WAKE_EN << 2) |-> avs_readdata == '0)
      else $error("enable register readable");
   chk_warm_pulse: assert property (warmup_start && clk_en
      |=> !warmup_start)
      else $error("warm-up pulse too long");
   chk_release_warm: assert property ($fell(clock_stop) |-> warmup_start)
      else $error("release without warm-up");
   chk_halt_rise: assert property (clock_stop && $rose(port2_bit0)
      |-> ##[1:5] !clock_stop)
      else $error("halt rise did not release");
   chk_stay_quiet: assert property (s_quiet [*5] |=> clock_stop)
      else $error("spurious release");
   chk_stop_nowarm: assert property (clock_stop |-> !warmup_start)
      else $error("warm-up while stopped");
endmodule // kws_stop_release_sva

bind kws_stop_release kws_stop_release_sva chk (.sys_clk(sys_clk),
   .resetn(resetn), .clk_en(clk_en), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .wake_key(wake_key),
   .port2_bit0(port2_bit0), .clock_stop(clock_stop),
   .warmup_start(warmup_start));

// File: kws_wake_detect.sv
`timescale 1ns/100ps
// Clockless wake request: must work while the system clock is stopped
module kws_wake_detect (
   kws_wake_if.det w
);
   // Enabled key pulled low, disabled keys masked out
   assign w.key_low   = |(w.wake_en & ~w.wake_key); // RQ3 RQ14
   // Halt pin has no enable and always takes part
   assign w.level_req = w.halt_pin | w.key_low;     // RQ8 RQ14
endmodule // kws_wake_detect

// File: kws_wake_if.sv
`timescale 1ns/100ps
interface kws_wake_if;
   logic [3:0] wake_key;    // Raw wake pins
   logic       halt_pin;    // Raw halt-release pin
   logic [3:0] wake_en;     // Enable bits from the register
   logic       key_low;     // Any enabled key held low, no clock
   logic       level_req;   // Level release request, no clock
   modport top (output wake_key, halt_pin, wake_en,
                input  key_low, level_req);
   modport det (input  wake_key, halt_pin, wake_en,
                output key_low, level_req);
endinterface // kws_wake_if

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top
   import kws_pkg::*;
   ;
   logic                  sys_clk, resetn, avs_read, avs_write;
   logic [KWS_ADDR_W-1:0] avs_address;
   logic [KWS_DATA_W-1:0] avs_writedata, avs_readdata;
   logic                  avs_waitrequest, port2_bit0;
   logic                  clock_stop, warmup_start, clk_en;
   logic [3:0]            wake_key;
   int                    num_errors = 0, n_checks = 0, n_warm = 0;
   localparam logic [15:0] A_EN = KWS_IDX_WAKE_EN << 2;
   localparam logic [15:0] A_CT = KWS_IDX_CTRL << 2;
   localparam logic [15:0] A_ST = KWS_IDX_STATUS << 2;
   kws_stop_release dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .wake_key(wake_key),
      .port2_bit0(port2_bit0), .clock_stop(clock_stop),
      .warmup_start(warmup_start));
   kws_key_model keys (.sys_clk(sys_clk), .wake_key(wake_key),
      .halt_pin(port2_bit0));
   ////////////////////////////////////////
   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Count warm-up pulses; the pulse lasts one cycle only
   always @(posedge sys_clk) if (warmup_start === 1'b1) n_warm++;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, {24'h0, d}, q);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask
   // Standby instruction; either it stops or it warms up at once
   task automatic stop_in(input logic relm, input logic stops);
      int w0;
      w0 = n_warm;
      wr(A_CT, {6'h0, 1'b1, relm});
      repeat (3) @(posedge sys_clk);
      check(clock_stop, stops);
      check(n_warm - w0, {31'h0, !stops});
   endtask
   // Pin reaches the core within four cycles; allow eight
   task automatic released();
      int w0;
      w0 = n_warm;
      repeat (8) @(posedge sys_clk);
      check(clock_stop, 1'b0);
      check(n_warm - w0, 32'h1);
   endtask
   ////////////////////////////////////////
   // Reset state, readback, halt release with all keys disabled
   task automatic t_reset();
      check(clock_stop, 1'b0);
      rd(A_EN, 32'h0);
      rd(16'h0100, 32'h0);
      rd(A_ST, 32'hf0);
      keys.set_key(2, 1'b0);
      repeat (4) @(posedge sys_clk);
      rd(A_ST, 32'hb0);
      stop_in(1'b1, 1'b1);
      keys.set_halt(1'b1);
      released();
      keys.set_halt(1'b0);
      keys.set_key(2, 1'b1);
   endtask
   // Release condition present at entry: no standby
   task automatic t_blocked();
      wr(A_EN, 8'h10);
      keys.set_key(0, 1'b0);
      repeat (4) @(posedge sys_clk);
      stop_in(1'b1, 1'b0);
      keys.set_key(0, 1'b1);
      wr(A_EN, 8'h00);
      keys.set_halt(1'b1);
      repeat (4) @(posedge sys_clk);
      stop_in(1'b0, 1'b0);
      keys.set_halt(1'b0);
      repeat (4) @(posedge sys_clk);
   endtask
   // Each key alone wakes; a disabled neighbour is ignored
   task automatic t_keys();
      for (int k = 0; k < 4; k++) begin
         wr(A_EN, 8'h10 << k);
         stop_in(1'b1, 1'b1);
         keys.set_key((k + 1) % 4, 1'b0);
         repeat (6) @(posedge sys_clk);
         check(clock_stop, 1'b1);
         keys.set_key(k, 1'b0);
         released();
         keys.set_key(k, 1'b1);
         keys.set_key((k + 1) % 4, 1'b1);
         repeat (4) @(posedge sys_clk);
      end
   endtask
   // Edge mode: keys disabled, only a halt rise releases
   task automatic t_edge();
      wr(A_EN, 8'h00);
      stop_in(1'b0, 1'b1);
      keys.set_key(0, 1'b0);
      repeat (6) @(posedge sys_clk);
      check(clock_stop, 1'b1);
      keys.set_key(0, 1'b1);
      keys.set_halt(1'b1);
      released();
      keys.set_halt(1'b0);
   endtask
   // Clock enable low freezes standby even with an enabled key pressed
   task automatic t_freeze();
      int w0;
      wr(A_EN, 8'h10);
      stop_in(1'b1, 1'b1);
      w0 = n_warm;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      keys.set_key(0, 1'b0);
      repeat (8) @(posedge sys_clk);
      check(clock_stop, 1'b1);
      check(n_warm - w0, 32'h0);
      clk_en <= 1'b1;
      released();
      keys.set_key(0, 1'b1);
      wr(A_EN, 8'h00);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence after four cycles of reset
   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_writedata = '0;
      clk_en = 1'b1;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_blocked();
      t_keys();
      t_edge();
      t_freeze();
      tally_and_finish();
   end
   // Whole run takes a few hundred cycles; cut off a hang
   initial begin
      #50us;
      num_errors++;
      tally_and_finish();
   end
endmodule // tb_top
